// >>> design/iof_pkg.sv
// constants for the input and relay force override block
// assumes a 16-bit register port with byte addresses on an 8-bit address
package iof_pkg;
    localparam int IOF_ADDR_W = 8;
    localparam int IOF_DATA_W = 16;
    localparam int IOF_NUM_DI = 6;
    localparam int IOF_NUM_RO = 3;
    localparam logic [7:0] IOF_ADDR_DI_SEL = 8'h00;
    localparam logic [7:0] IOF_ADDR_DI_FORCED = 8'h04;
    localparam logic [7:0] IOF_ADDR_DI_STATUS = 8'h08;
    localparam logic [7:0] IOF_ADDR_RO_STATUS = 8'h0C;
    localparam logic [7:0] IOF_ADDR_RO_SEL = 8'h10;
    localparam logic [7:0] IOF_ADDR_RO_FORCED = 8'h14;
    localparam logic [5:0] IOF_DI_SEL_RST = 6'h00;
    localparam logic [15:0] IOF_DI_FORCED_RST = 16'h0000;
    localparam logic [2:0] IOF_RO_SEL_RST = 3'h0;
    localparam logic [15:0] IOF_RO_FORCED_RST = 16'h0000;
    localparam logic [15:0] IOF_RDATA_IDLE = 16'h0000;
    localparam logic [5:0] IOF_DI_LOW_MASK = 6'h03;
    localparam logic [5:0] IOF_DI_HIGH_MASK = 6'h3C;
endpackage

// >>> design/iof_sync.sv
// three-stage synchroniser for the digital input pins
// assumes pins are asynchronous to core_clk; output follows once stages two and three agree
`timescale 1ns/1ps
module iof_sync
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [5:0] pin_in,
    output logic [5:0] stable_out
);
    logic [5:0] meta_r;
    logic [5:0] sync2_r;
    logic [5:0] sync3_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= 6'h00;
            sync2_r <= 6'h00;
            sync3_r <= 6'h00;
        end
        else
        begin
            meta_r <= pin_in;
            sync2_r <= meta_r;
            sync3_r <= sync2_r;
        end
    end

    // per bit: a change counts only when the last two stages agree
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stable_out <= 6'h00;
        end
        else
        begin
            stable_out <= (sync2_r & ~(sync2_r ^ sync3_r)) | (stable_out & (sync2_r ^ sync3_r));
        end
    end
endmodule

// >>> design/iof_top.sv
// force override of six digital inputs and three relay outputs
// assumes a register master on core_clk, asynchronous input pins, same-clock relay sources
//
// Notes on behaviour
// - input select bits 2..5 force inputs three..six from forced bits 2..5
// - forced bit changes an input only while its select bit is set
// - forced-value word bit 0 is input one, bit 5 input six
// - relay status bit 0 is relay one, one means energized
// - relay select bits 0..2 steer relays one..three from same-numbered forced bits
// - relay forced bits only act on relays that are selected
// - reset clears all select and forced-value words
// - input select bits 0 and 1 force inputs one and two
`timescale 1ns/1ps
module iof_top
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [5:0] digital_input_pin,
    output logic [5:0] digital_input_seen,
    input wire logic [2:0] relay_output_source,
    output logic [2:0] relay_output_drive
);
    logic [5:0] di_sel_r;
    logic [15:0] di_forced_r;
    logic [2:0] ro_sel_r;
    logic [15:0] ro_forced_r;
    logic [5:0] di_stable;
    logic [5:0] di_seen_r;
    logic [5:0] di_seen_nxt;
    logic [2:0] ro_drive_r;
    logic [2:0] ro_drive_nxt;
    logic [5:0] ro_pick;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // per-bit mux: select high takes the forced bit, else the live bit
    function automatic logic [5:0] pick(input logic [5:0] sel, input logic [5:0] forced,
                                        input logic [5:0] live);
        pick = (sel & forced) | (~sel & live);
    endfunction

    iof_sync u_sync
    (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(digital_input_pin),
        .stable_out(di_stable)
    );

    // select words hold only implemented bits, so reserved ones cannot steer anything
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            di_sel_r <= iof_pkg::IOF_DI_SEL_RST;
            di_forced_r <= iof_pkg::IOF_DI_FORCED_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == iof_pkg::IOF_ADDR_DI_SEL)
            begin
                di_sel_r <= reg_wdata[5:0];
            end
            if (reg_addr == iof_pkg::IOF_ADDR_DI_FORCED)
            begin
                di_forced_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ro_sel_r <= iof_pkg::IOF_RO_SEL_RST;
            ro_forced_r <= iof_pkg::IOF_RO_FORCED_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == iof_pkg::IOF_ADDR_RO_SEL)
            begin
                ro_sel_r <= reg_wdata[2:0];
            end
            if (reg_addr == iof_pkg::IOF_ADDR_RO_FORCED)
            begin
                ro_forced_r <= reg_wdata;
            end
        end
    end

    always_comb
    begin
        di_seen_nxt = pick(di_sel_r, di_forced_r[5:0], di_stable);
    end

    always_comb
    begin
        // relays share the six-wide mux, upper lanes held at zero
        ro_pick = pick({3'h0, ro_sel_r}, {3'h0, ro_forced_r[2:0]}, {3'h0, relay_output_source});
        ro_drive_nxt = ro_pick[2:0];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            di_seen_r <= 6'h00;
        end
        else
        begin
            di_seen_r <= di_seen_nxt;
        end
    end

    // relays start de-energized until the first edge after reset
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ro_drive_r <= 3'h0;
        end
        else
        begin
            ro_drive_r <= ro_drive_nxt;
        end
    end

    always_comb
    begin
        rdata_nxt = iof_pkg::IOF_RDATA_IDLE;
        case (reg_addr)
            iof_pkg::IOF_ADDR_DI_SEL: rdata_nxt = {10'h000, di_sel_r};
            iof_pkg::IOF_ADDR_DI_FORCED: rdata_nxt = di_forced_r;
            iof_pkg::IOF_ADDR_DI_STATUS: rdata_nxt = {10'h000, di_seen_r};
            iof_pkg::IOF_ADDR_RO_STATUS: rdata_nxt = {13'h0000, ro_drive_r};
            iof_pkg::IOF_ADDR_RO_SEL: rdata_nxt = {13'h0000, ro_sel_r};
            iof_pkg::IOF_ADDR_RO_FORCED: rdata_nxt = ro_forced_r;
            default: rdata_nxt = iof_pkg::IOF_RDATA_IDLE;
        endcase
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= iof_pkg::IOF_RDATA_IDLE;
        end
        else if (reg_rd)
        begin
            rdata_r <= rdata_nxt;
        end
        else
        begin
            rdata_r <= iof_pkg::IOF_RDATA_IDLE;
        end
    end

    assign reg_rdata = rdata_r;
    assign digital_input_seen = di_seen_r;
    assign relay_output_drive = ro_drive_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_di_high_force: assert property
        (((di_seen_r ^ $past(di_forced_r[5:0])) & $past(di_sel_r) & iof_pkg::IOF_DI_HIGH_MASK) == 6'h00)
        else $error("selected input three..six not at forced value");

    chk_di_live_pass: assert property
        (((di_seen_r ^ $past(di_stable)) & ~$past(di_sel_r)) == 6'h00)
        else $error("unselected input not following live state");

    chk_di_bit_order: assert property
        ($past(di_sel_r[5]) && !$past(di_forced_r[5]) && $past(di_forced_r[0]) && $past(di_sel_r[0])
         |-> !di_seen_r[5] && di_seen_r[0])
        else $error("forced bit order wrong for inputs one and six");

    chk_ro_status_read: assert property
        (reg_rd && reg_addr == iof_pkg::IOF_ADDR_RO_STATUS
         |=> reg_rdata == {13'h0000, $past(ro_drive_r)})
        else $error("relay status read does not show relay drive");

    chk_ro_force_take: assert property
        (ro_sel_r[1] && !reg_wr |=> relay_output_drive[1] == $past(ro_forced_r[1]))
        else $error("selected relay two not driven from forced bit");

    chk_ro_sel_map: assert property
        (((relay_output_drive ^ $past(ro_forced_r[2:0])) & $past(ro_sel_r)) == 3'h0)
        else $error("relay select does not map to same-numbered forced bit");

    chk_ro_unsel_src: assert property
        // the drive register sits in reset at the edge of release, so skip that edge
        (!$past(rst) |-> ((relay_output_drive ^ $past(relay_output_source)) & ~$past(ro_sel_r)) == 3'h0)
        else $error("unselected relay not following its source");

    chk_reset_clear: assert property
        ($past(rst) |-> di_sel_r == 6'h00 && di_forced_r == 16'h0000 && ro_sel_r == 3'h0
         && ro_forced_r == 16'h0000)
        else $error("force words not clear after reset");

    chk_di_low_force: assert property
        (((di_seen_r ^ $past(di_forced_r[5:0])) & $past(di_sel_r) & iof_pkg::IOF_DI_LOW_MASK) == 6'h00)
        else $error("selected input one or two not at forced value");

    chk_sel_reserved_zero: assert property
        (reg_rd && reg_addr == iof_pkg::IOF_ADDR_RO_SEL |=> reg_rdata[15:3] == 13'h0000)
        else $error("reserved relay select bits read nonzero");

    cov_di_forced: cover property (di_sel_r[2] && di_forced_r[2] && !di_stable[2] ##1 di_seen_r[2]);
    cov_ro_forced: cover property (ro_sel_r[1] && ro_forced_r[1] && !relay_output_source[1]
                                   ##1 relay_output_drive[1]);
    cov_ro_release: cover property (ro_sel_r[0] ##1 !ro_sel_r[0]);
endmodule

// >>> dv/iof_far_model.sv
// far side of the override block: input contacts and relay coils
// assumes the bench sets contact levels; relay coils follow the drive lines
`timescale 1ns/1ps
module iof_far_model
(
    input wire logic [5:0] pin_level,
    output logic [5:0] digital_input_pin,
    input wire logic [2:0] relay_output_drive,
    output logic [2:0] relay_energized
);
    // contacts move off the clock edge, as real wiring does
    assign #7 digital_input_pin = pin_level;
    // a driven line means the coil is energized
    assign relay_energized = relay_output_drive;
endmodule

// >>> dv/tb.sv
// self-checking bench for the input and relay force override block
// assumes the far side model drives the pins and reports the relay coils
`timescale 1ns/1ps
module tb;
    logic core_clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [5:0] pin_level;
    logic [5:0] digital_input_pin;
    logic [5:0] digital_input_seen;
    logic [2:0] relay_output_source;
    logic [2:0] relay_output_drive;
    logic [2:0] relay_energized;
    int failures = 0;
    int comparisons = 0;

    iof_top i_iof_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .digital_input_pin(digital_input_pin),
        .digital_input_seen(digital_input_seen), .relay_output_source(relay_output_source),
        .relay_output_drive(relay_output_drive));
    iof_far_model i_iof_far_model (.pin_level(pin_level), .digital_input_pin(digital_input_pin),
        .relay_output_drive(relay_output_drive), .relay_energized(relay_energized));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic test_reset_values();
        rd(iof_pkg::IOF_ADDR_DI_SEL, 16'h0000);
        rd(iof_pkg::IOF_ADDR_DI_FORCED, 16'h0000);
        rd(iof_pkg::IOF_ADDR_RO_SEL, 16'h0000);
        rd(iof_pkg::IOF_ADDR_RO_FORCED, 16'h0000);
        rd(8'h40, 16'h0000);
    endtask

    task automatic test_input_force();
        logic [15:0] sels [4];
        logic [5:0] exp;
        sels = '{16'h0003, 16'h003C, 16'h0021, 16'hFFC0};
        @(posedge core_clk);
        pin_level <= 6'h2A;
        repeat (8) @(posedge core_clk);
        #1 chk({10'h000, digital_input_seen}, 16'h002A);
        wr(iof_pkg::IOF_ADDR_DI_FORCED, 16'hAB15);
        rd(iof_pkg::IOF_ADDR_DI_FORCED, 16'hAB15);
        foreach (sels[i])
        begin
            wr(iof_pkg::IOF_ADDR_DI_SEL, sels[i]);
            repeat (2) @(posedge core_clk);
            exp = (6'h2A & ~sels[i][5:0]) | (6'h15 & sels[i][5:0]);
            #1 chk({10'h000, digital_input_seen}, {10'h000, exp});
            rd(iof_pkg::IOF_ADDR_DI_SEL, {10'h000, sels[i][5:0]});
        end
        rd(iof_pkg::IOF_ADDR_DI_STATUS, 16'h002A);
    endtask

    task automatic test_relay_force();
        logic [15:0] sel;
        logic [2:0] exp;
        @(posedge core_clk);
        // forced bits opposite to the source on every relay
        relay_output_source <= 3'h5;
        wr(iof_pkg::IOF_ADDR_RO_FORCED, 16'h0002);
        for (int i = 0; i < 9; i++)
        begin
            sel = (i == 8) ? 16'hFFF8 : 16'(i);
            wr(iof_pkg::IOF_ADDR_RO_SEL, sel);
            repeat (2) @(posedge core_clk);
            exp = (3'h5 & ~sel[2:0]) | (3'h2 & sel[2:0]);
            #1 chk({13'h0000, relay_output_drive}, {13'h0000, exp});
            chk({13'h0000, relay_energized}, {13'h0000, exp});
            rd(iof_pkg::IOF_ADDR_RO_STATUS, {13'h0000, exp});
            rd(iof_pkg::IOF_ADDR_RO_SEL, {13'h0000, sel[2:0]});
        end
    endtask

    // a restart in mid-run must drop every override
    task automatic test_reset_clears();
        wr(iof_pkg::IOF_ADDR_RO_SEL, 16'h0007);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk({13'h0000, relay_output_drive}, {13'h0000, relay_output_source});
        test_reset_values();
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial
    begin
        #(25 * 3000);
        failures++;
        end_of_test();
    end

    initial
    begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pin_level = 6'h00;
        relay_output_source = 3'h0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        test_reset_values();
        test_input_force();
        test_relay_force();
        test_reset_clears();
        end_of_test();
    end
endmodule
